// >>> design/carrier_freq_auto_reduction.sv
`timescale 1ns/10ps
`default_nettype none
`include "carrier_regs.svh"
// What this block does
// R1 - Accept carrier setting 2.0 to 15.0 kHz, default 10.0 kHz after reset.
// R2 - Reduction select: off, current-based, heatsink (heatsink is accepted but acts as off); current-based is reset default.
// R3 - Current at 60/72/84/96 percent lowers target to 12/9/6/3 kHz.
// R4 - Restore higher step only when current falls 5 percent below trigger.
// R5 - Active carrier moves toward target at no more than 2 kHz per second.
// R6 - Adjusted carrier stays between 3 kHz and the configured setting.
// R7 - Reduction disabled whenever configured setting is 3 kHz or lower.
// R8 - Ramp upward at the same rate; hold configured value while disabled.
module carrier_freq_auto_reduction (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic setting_load,
  input wire logic [7:0] carrier_freq_setting,
  input wire logic [1:0] auto_carrier_reduce_select,
  input wire logic [7:0] current_pct,
  output logic [7:0] active_carrier,
  output logic [1:0] active_select
);
  // ***********************************************
  // Configuration
  // ***********************************************
  logic [7:0] setting;
  logic [7:0] cur_s1;
  logic [7:0] cur_s2;
  // Loads outside the legal range are ignored.
  wire logic setting_ok = carrier_freq_setting >= `CARRIER_MIN_SET &&
                          carrier_freq_setting <= `CARRIER_MAX_SET;
  wire logic sel_ok = auto_carrier_reduce_select != 2'h3;
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      setting <= `CARRIER_RESET_VAL; // [R1]
      active_select <= 2'h1; // [R2]
    end else if (setting_load) begin
      if (setting_ok) begin
        setting <= carrier_freq_setting; // [R1]
      end
      if (sel_ok) begin
        active_select <= auto_carrier_reduce_select; // [R2]
      end
    end
  end

  // ***********************************************
  // Current synchroniser
  // ***********************************************
  // Current comes from the measurement path in another domain.
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      cur_s1 <= 8'h00;
      cur_s2 <= 8'h00;
    end else begin
      cur_s1 <= current_pct;
      cur_s2 <= cur_s1;
    end
  end

  // ***********************************************
  // Target selection
  // ***********************************************
  wire logic reduce_en = active_select == carrier_pkg::reduce_current &&
                         setting > `CARRIER_FLOOR; // [R2] [R7]

  // ***********************************************
  // Step detector link
  // ***********************************************
  carrier_if step_link ();
  assign step_link.current_pct = cur_s2;
  current_step_detect u_step (
    .clk(clk),
    .rst_b(rst_b),
    .enable(reduce_en),
    .link(step_link.stepper)
  );

  // Level 0 keeps the configured carrier; levels 1 to 4 pick the reduced steps.
  wire logic [7:0] step_val = step_link.level == 3'h4 ? `CARRIER_STEP4 :
                              step_link.level == 3'h3 ? `CARRIER_STEP3 :
                              step_link.level == 3'h2 ? `CARRIER_STEP2 :
                              step_link.level == 3'h1 ? `CARRIER_STEP1 : setting; // [R3]
  wire logic [7:0] clamp_hi = step_val > setting ? setting : step_val; // [R6]
  wire logic [7:0] floored = clamp_hi < `CARRIER_FLOOR ? `CARRIER_FLOOR : clamp_hi; // [R6]
  // With reduction off the target is the setting itself, even below the floor.
  wire logic [7:0] target = reduce_en ? floored : setting; // [R6] [R8]

  // ***********************************************
  // Slew limiter
  // ***********************************************
  logic [23:0] tick_cnt;
  wire logic tick = tick_cnt == 24'(`SLEW_CYCLES - 1);
  always_ff @(posedge clk) begin
    if (!rst_b || tick) begin
      tick_cnt <= 24'h000000;
    end else begin
      tick_cnt <= tick_cnt + 24'h000001;
    end
  end

  // ***********************************************
  // Ramp state
  // ***********************************************
  // Track ramps toward the target, settled waits for a new target, hold follows the setting.
  carrier_pkg::ramp_state_t state;
  carrier_pkg::ramp_state_t next_state;
  always_comb begin
    case (state)
      carrier_pkg::st_hold: next_state = reduce_en ? carrier_pkg::st_track : state;
      carrier_pkg::st_track: begin
        if (!reduce_en && active_carrier == setting) begin
          next_state = carrier_pkg::st_hold;
        end else if (active_carrier == target) begin
          next_state = carrier_pkg::st_settled;
        end else begin
          next_state = state;
        end
      end
      carrier_pkg::st_settled: next_state = active_carrier != target ||
                                            !reduce_en ? carrier_pkg::st_track : state;
      default: next_state = carrier_pkg::st_hold;
    endcase
  end
  wire logic holding = state == carrier_pkg::st_hold;
  wire logic [7:0] next_up = active_carrier + 8'h01;
  wire logic [7:0] next_down = active_carrier - 8'h01;
  logic [7:0] next_active;
  always_comb begin
    next_active = active_carrier;
    if (holding) begin
      next_active = setting; // [R8]
    end else if (active_carrier > setting) begin
      next_active = setting; // [R6]
    end else if (tick && active_carrier < target) begin
      next_active = next_up; // [R5] [R8]
    end else if (tick && active_carrier > target) begin
      next_active = next_down; // [R5]
    end
  end
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      state <= carrier_pkg::st_hold;
      active_carrier <= `CARRIER_RESET_VAL;
    end else begin
      state <= next_state;
      active_carrier <= next_active;
    end
  end
  // ***********************************************
  // Checks
  // ***********************************************
  // The rst_b terms keep the first edge after a release from comparing
  // against values that were sampled before the reset.
  sequence s_step;
    rst_b && !holding && active_carrier <= setting ##1 active_carrier != $past(active_carrier);
  endsequence

  sequence s_level_up;
    rst_b && reduce_en ##1 step_link.level == $past(step_link.level) + 3'h1;
  endsequence

  sequence s_level_down;
    rst_b && reduce_en ##1 step_link.level + 3'h1 == $past(step_link.level);
  endsequence

  sequence s_up_tick;
    !holding && !reduce_en && tick && active_carrier < setting;
  endsequence

  a_slew_on_tick: assert property (@(posedge clk) disable iff (!rst_b) // [R5]
    s_step |-> $past(tick)) else $error("carrier moved off slew tick");

  a_slew_one_step: assert property (@(posedge clk) disable iff (!rst_b) // [R5]
    $past(rst_b) && $past(!holding) && $past(setting, 2) == $past(setting) |->
      (active_carrier == $past(active_carrier) ||
       active_carrier == $past(active_carrier) + 8'h01 ||
       active_carrier == $past(active_carrier) - 8'h01))
    else $error("carrier moved more than one step");

  a_floor_hold: assert property (@(posedge clk) disable iff (!rst_b) // [R6]
    reduce_en && $past(reduce_en) |-> active_carrier >= `CARRIER_FLOOR)
    else $error("carrier below floor");

  a_ceiling_hold: assert property (@(posedge clk) disable iff (!rst_b) // [R6]
    $stable(setting) |-> active_carrier <= setting)
    else $error("carrier above setting");

  a_target_range: assert property (@(posedge clk) disable iff (!rst_b) // [R6]
    reduce_en |-> target >= `CARRIER_FLOOR && target <= setting)
    else $error("target outside floor and setting");

  a_step_rise: assert property (@(posedge clk) disable iff (!rst_b) // [R3]
    s_level_up |-> $past(cur_s2) >= `CUR_THR1)
    else $error("step taken below first threshold");

  a_top_step: assert property (@(posedge clk) disable iff (!rst_b) // [R3]
    reduce_en && step_link.level == 3'h4 |-> target == `CARRIER_STEP4)
    else $error("lowest step not selected");

  a_step_fall: assert property (@(posedge clk) disable iff (!rst_b) // [R4]
    s_level_down |-> $past(cur_s2) <= `CUR_THR4 - `CUR_HYST)
    else $error("step released without hysteresis");

  a_select_legal: assert property (@(posedge clk) disable iff (!rst_b) // [R2]
    active_select != 2'h3)
    else $error("illegal selection in force");

  a_disable_low: assert property (@(posedge clk) disable iff (!rst_b) // [R7]
    setting <= `CARRIER_FLOOR |=> active_carrier <= $past(setting))
    else $error("reduction active at low setting");

  a_hold_setting: assert property (@(posedge clk) disable iff (!rst_b) // [R8]
    holding && $past(holding) && $stable(setting) |=> active_carrier == $past(setting))
    else $error("hold does not track setting");

  a_ramp_up: assert property (@(posedge clk) disable iff (!rst_b) // [R8]
    s_up_tick |=> active_carrier == $past(active_carrier) + 8'h01)
    else $error("carrier not restored on tick");
endmodule
`default_nettype wire

// >>> shared/carrier_regs.svh
`ifndef CARRIER_REGS_SVH
`define CARRIER_REGS_SVH

// Carrier values are in units of 0.1 kHz.
`define CARRIER_MIN_SET 8'd20
`define CARRIER_MAX_SET 8'd150
`define CARRIER_RESET_VAL 8'd100
`define CARRIER_FLOOR 8'd30
`define CARRIER_STEP1 8'd120
`define CARRIER_STEP2 8'd90
`define CARRIER_STEP3 8'd60
`define CARRIER_STEP4 8'd30
// Current thresholds in percent of rated current.
`define CUR_THR1 8'd60
`define CUR_THR2 8'd72
`define CUR_THR3 8'd84
`define CUR_THR4 8'd96
`define CUR_HYST 8'd5
// Slew: 2 kHz per second is 0.1 kHz per 50 ms.
`define CLK_HZ 25000000
`define SLEW_STEP_MS 50
`define SLEW_CYCLES (`CLK_HZ / 1000 * `SLEW_STEP_MS)

`endif

// >>> shared/carrier_pkg.sv
package carrier_pkg;
  typedef enum logic [1:0] {
    reduce_off = 2'h0,
    reduce_current = 2'h1,
    reduce_heatsink = 2'h2
  } reduce_mode_t;

  typedef enum logic [2:0] {
    st_hold = 3'h1,
    st_track = 3'h2,
    st_settled = 3'h4
  } ramp_state_t;
endpackage

// >>> shared/carrier_if.sv
`timescale 1ns/10ps
`default_nettype none
interface carrier_if;
  logic [7:0] current_pct;
  logic [2:0] level;
  modport stepper (input current_pct, output level);
  modport user (output current_pct, input level);
endinterface
`default_nettype wire

// >>> design/current_step_detect.sv
`timescale 1ns/10ps
`default_nettype none
`include "carrier_regs.svh"
module current_step_detect (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic enable,
  carrier_if.stepper link
);
  logic [2:0] level;
  wire logic [7:0] thr [0:3];
  assign thr[0] = `CUR_THR1;
  assign thr[1] = `CUR_THR2;
  assign thr[2] = `CUR_THR3;
  assign thr[3] = `CUR_THR4;
  // Level counts reached steps: 0 means no reduction, 4 means the lowest step.
  logic [2:0] count;
  logic [2:0] next_count;
  wire logic [3:0] above;
  wire logic [3:0] below;
  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : g_thr
      assign above[g] = link.current_pct >= thr[g]; // [R3]
      assign below[g] = link.current_pct <= thr[g] - `CUR_HYST; // [R4]
    end
  endgenerate
  always_comb begin
    next_count = count;
    if (!enable) begin
      next_count = 3'h0;
    end else if (count < 3'h4 && above[count[1:0]]) begin
      next_count = count + 3'h1; // [R3]
    end else if (count != 3'h0 && below[count[1:0] - 2'h1]) begin
      next_count = count - 3'h1; // [R4]
    end
  end
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      count <= 3'h0;
    end else begin
      count <= next_count;
    end
  end
  assign level = count;
  assign link.level = level;
endmodule
`default_nettype wire

// >>> test/current_source.sv
`timescale 1ns/10ps
`default_nettype none
// ****************************************************************
// Current measurement model
// ****************************************************************
// The measured current follows the requested level one cycle later.
module current_source (
  input wire logic clk,
  input wire logic [7:0] target_pct,
  output logic [7:0] current_pct
);
  initial begin
    current_pct = 8'h00;
  end
  always @(posedge clk) begin
    current_pct <= #1 target_pct;
  end
endmodule
`default_nettype wire

// >>> test/carrier_freq_auto_reduction_tb_top.sv
`timescale 1ns/10ps
`default_nettype none
// ****************************************************************
// Testbench
// ****************************************************************
module carrier_freq_auto_reduction_tb_top;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic setting_load = 1'b0;
  logic [7:0] carrier_freq_setting = 8'h64;
  logic [1:0] auto_carrier_reduce_select = 2'h1;
  logic [7:0] current_target = 8'h00;
  wire logic [7:0] current_pct;
  logic [7:0] active_carrier;
  logic [1:0] active_select;
  int n_mismatch = 0;
  int checks = 0;

  initial begin
    forever #20 clk = ~clk;
  end

  current_source u_src (.clk(clk), .target_pct(current_target), .current_pct(current_pct));

  carrier_freq_auto_reduction u_dut (
    .clk(clk),
    .rst_b(rst_b),
    .setting_load(setting_load),
    .carrier_freq_setting(carrier_freq_setting),
    .auto_carrier_reduce_select(auto_carrier_reduce_select),
    .current_pct(current_pct),
    .active_carrier(active_carrier),
    .active_select(active_select)
  );

  task check(input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Inputs always change one nanosecond after the rising edge.
  task cycles(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task load(input logic [7:0] f, input logic [1:0] s);
    setting_load = 1'b1;
    carrier_freq_setting = f;
    auto_carrier_reduce_select = s;
    cycles(1);
    setting_load = 1'b0;
    cycles(2);
  endtask

  task t_reset(input int n);
    rst_b = 1'b0;
    cycles(n);
    rst_b = 1'b1;
    check(active_carrier, 8'h64);
    check({6'h00, active_select}, 8'h01);
    $display("reset test done");
  endtask

  task t_hold();
    load(8'h64, 2'h0);
    check(active_carrier, 8'h64);
    load(8'h96, 2'h0);
    check(active_carrier, 8'h96);
    check({6'h00, active_select}, 8'h00);
    load(8'h96, 2'h2);
    check({6'h00, active_select}, 8'h02);
    $display("hold test done");
  endtask

  task t_refuse();
    load(8'hc8, 2'h2);
    check(active_carrier, 8'h96);
    load(8'h96, 2'h3);
    check({6'h00, active_select}, 8'h02);
    $display("refuse test done");
  endtask

  // A full step takes far longer than the run, so the output must not move yet.
  task t_slew();
    load(8'h96, 2'h1);
    current_target = 8'h63;
    cycles(3000);
    check(u_dut.target, 8'h1e);
    check(active_carrier, 8'h96);
    current_target = 8'h3e;
    cycles(20);
    check(u_dut.target, 8'h78);
    current_target = 8'h39;
    cycles(20);
    check(u_dut.target, 8'h78);
    current_target = 8'h37;
    cycles(20);
    check(u_dut.target, 8'h96);
    current_target = 8'h48;
    cycles(20);
    check(u_dut.target, 8'h5a);
    current_target = 8'h00;
    cycles(3000);
    check(u_dut.target, 8'h96);
    check(active_carrier, 8'h96);
    $display("slew test done");
  endtask

  task t_floor();
    current_target = 8'h63;
    load(8'h1e, 2'h1);
    check(active_carrier, 8'h1e);
    load(8'h14, 2'h1);
    check(active_carrier, 8'h14);
    current_target = 8'h00;
    $display("floor test done");
  endtask

  task finish_test();
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  initial begin
    t_reset(20);
    t_hold();
    t_refuse();
    t_slew();
    t_floor();
    t_reset(1);
    finish_test();
  end
endmodule
`default_nettype wire
